/* File: rom_map_defs.vh */
// Register offsets, field positions and reset values for the bus info and ROM map registers
// Behaviour
// - The max request code resets so that two to the power of code plus one is at least 512 bytes.
// - A system reset sets the max request code for 2048 bytes and a software reset leaves it alone.
// - Software may rewrite the max request code but keeps it valid while link_on is set.
// - A received block write longer than the max request byte count may get ack_type_error.
// - Bus options bits 11 to 8 and 5 to 3 always read as zero.
// - The read-only link speed code reads 010 for 100, 200 and 400 Mbit/s.
// - The upper unique ID quadlet is read-only and holds vendor and upper chip ID bits.
// - Both unique ID quadlets clear to zero on a system reset, an illegal value until loaded.
// - With an EEPROM present, the unique ID is loaded through the EEPROM port after reset and then locked.
// - The lower unique ID quadlet behaves exactly as the upper one.
// - A quadlet read to FFFF_F000_0400 to 07FF adds the low 10 offset bits to the ROM map base.
// - The ROM map base holds writable bits 31 to 10, resets to zero, and bits 9 to 0 read zero.
`ifndef ROM_MAP_DEFS_VH
`define ROM_MAP_DEFS_VH
`define OFS_BUS_OPTIONS 8'h20
`define OFS_UID_UPPER 8'h24
`define OFS_UID_LOWER 8'h28
`define OFS_ROM_MAP_BASE 8'h34
`define OFS_HC_CONTROL_SET 8'h50
`define OFS_HC_CONTROL_CLR 8'h54
`define LINK_ON_BIT 17
`define MAX_REC_RESET 4'hA
`define MAX_REC_MIN 4'h8
`define LINK_SPEED_CODE 3'h2
`define BUS_OPT_UPPER_RESET 8'h00
`define CYC_ACC_RESET 8'h00
`define ROM_CSR_HI 20'hFFFFF
`define ROM_CSR_MID 12'h000
`define ROM_WIN_LO 6'h01
`define ROM_BASE_RESET 22'h000000
`define ROM_BASE_LSB 10
`endif

/* File: rom_read_xlate.v */
// Translation of 1394 configuration ROM quadlet reads into host memory addresses
`timescale 1ns/1ps
`include "rom_map_defs.vh"
module rom_read_xlate (
   input wire ref_clk,
   input wire rst,
   input wire req_valid,
   input wire [47:0] req_offset,
   input wire [21:0] map_base,
   output reg hit_r,
   output reg miss_r,
   output reg [31:0] host_addr_r
);
   wire in_window;
   assign in_window = (req_offset[47:28] == `ROM_CSR_HI) &&
                      (req_offset[27:16] == `ROM_CSR_MID) &&
                      (req_offset[15:10] == `ROM_WIN_LO);

   // base plus low ten bits; base is 1 KB aligned, so the add is a concatenation
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hit_r <= 1'b0;
         miss_r <= 1'b0;
         host_addr_r <= 32'h00000000;
      end else begin
         hit_r <= req_valid & in_window;
         miss_r <= req_valid & ~in_window;
         if (req_valid & in_window) begin
            host_addr_r <= {map_base, req_offset[9:0]};
         end
      end
   end
endmodule

/* File: bus_info_and_rom_map_regs.v */
// Bus options, unique ID and ROM map base registers of the link controller
`timescale 1ns/1ps
`include "rom_map_defs.vh"
module bus_info_and_rom_map_regs (
   // Clock, system reset and software reset
   input wire ref_clk,
   input wire rst,
   input wire soft_rst,
   // Host register access, one strobe per word
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata_r,
   output reg reg_rack_r,
   // Serial EEPROM load port and unique ID lock status
   input wire eeprom_present,
   input wire eeprom_valid,
   input wire [63:0] eeprom_uid,
   output reg uid_locked_r,
   // Link-on control bit toward the link core
   output reg link_on_r,
   // Configuration ROM read translation, driven by the translator's flops
   input wire rom_req_valid,
   input wire [47:0] rom_req_offset,
   output wire rom_hit_r,
   output wire rom_miss_r,
   output wire [31:0] rom_host_addr_r,
   // Received block write length check
   input wire wr_req_valid,
   input wire [15:0] wr_req_len,
   output reg wr_type_error_r
);
   // Register map, byte offsets seen by the host:
   //   20h bus options: 31-27 R/W, 23-16 accuracy, 15-12 max request, 7-6 generation
   //   24h upper unique ID quadlet, read-only
   //   28h lower unique ID quadlet, read-only
   //   34h ROM map base, bits 31-10 R/W and bits 9-0 read zero
   //   50h/54h control set/clear, only the link-on bit 17 is kept here
   // Writes to any other offset are dropped, and reads of them return zero.
   // The generation count is plain software data; hardware never bumps it.

   // Bus options fields
   reg [7:0] bus_opt_upper_r;
   reg [7:0] cyc_acc_r;
   reg [3:0] max_rec_r;
   reg [1:0] gen_r;
   // Unique ID quadlets and their load control
   reg [31:0] uid_upper_r;
   reg [31:0] uid_lower_r;
   reg [1:0] eep_sync_r;
   reg eep_load_pending_r;
   // ROM map base, bits 31 to 10 only
   reg [21:0] rom_base_r;
   // Read path and derived values
   reg [31:0] rd_nxt;
   wire [31:0] opt_word;
   wire [3:0] max_rec_nxt;
   wire [4:0] max_rec_pow;
   wire [16:0] max_rec_bytes;
   // Decoded write strobes
   wire wr_opts;
   wire wr_hc_set;
   wire wr_hc_clr;
   wire wr_base;

   // One decode per writable offset
   assign wr_opts = reg_wr && (reg_addr == `OFS_BUS_OPTIONS);
   assign wr_hc_set = reg_wr && (reg_addr == `OFS_HC_CONTROL_SET);
   assign wr_hc_clr = reg_wr && (reg_addr == `OFS_HC_CONTROL_CLR);
   assign wr_base = reg_wr && (reg_addr == `OFS_ROM_MAP_BASE);
   // unique ID offsets have no write decode
   // A stray host write there can never disturb a loaded identifier

   // keep a rewritten code valid; codes below 512 bytes are refused
   assign max_rec_nxt = (reg_wdata[15:12] >= `MAX_REC_MIN) ? reg_wdata[15:12] : max_rec_r;
   // request limit in bytes, two to the power of code plus one
   // The exponent is one bit wider so that code F gives 64 KiB instead of wrapping to 1
   assign max_rec_pow = {1'b0, max_rec_r} + 5'h01;
   assign max_rec_bytes = 17'h00001 << max_rec_pow;

   // bus options as read: reserved fields zero, fixed speed code
   assign opt_word = {bus_opt_upper_r, cyc_acc_r, max_rec_r, 4'h0, gen_r, 3'b000,
                      `LINK_SPEED_CODE};

   // Presence strap from a pin passes two flops before use
   // Only the second flop is read, so a strap edge near the clock cannot split a load
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eep_sync_r <= 2'b00;
      end else begin
         eep_sync_r <= {eep_sync_r[0], eeprom_present};
      end
   end

   // Bus options; the max request code survives a software reset
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         max_rec_r <= `MAX_REC_RESET;
         bus_opt_upper_r <= `BUS_OPT_UPPER_RESET;
         cyc_acc_r <= `CYC_ACC_RESET;
         gen_r <= 2'b00;
      end else if (soft_rst) begin
         bus_opt_upper_r <= `BUS_OPT_UPPER_RESET;
         cyc_acc_r <= `CYC_ACC_RESET;
         gen_r <= 2'b00;
      end else if (wr_opts) begin
         // Bits 26 to 24 are read-only zero, so only 31 to 27 are stored
         bus_opt_upper_r <= {reg_wdata[31:27], 3'b000};
         cyc_acc_r <= reg_wdata[23:16];
         max_rec_r <= max_rec_nxt;
         gen_r <= reg_wdata[7:6];
      end
   end

   // Link-on bit from the control set/clear pair
   // Software reset drops the link so that stale bus options are never advertised
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         link_on_r <= 1'b0;
      end else if (soft_rst) begin
         link_on_r <= 1'b0;
      end else if (wr_hc_set && reg_wdata[`LINK_ON_BIT]) begin
         link_on_r <= 1'b1;
      end else if (wr_hc_clr && reg_wdata[`LINK_ON_BIT]) begin
         link_on_r <= 1'b0;
      end
   end

   // Unique ID: zero after reset, one EEPROM load, then locked
   // The pending flag closes the load window for good, so a late or repeated
   // EEPROM strobe cannot change an identifier that software may already hold.
   // Without an EEPROM the quadlets keep the illegal zero value; the pending flag stays set, so an EEPROM fitted later still loads.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         uid_upper_r <= 32'h00000000;
         uid_lower_r <= 32'h00000000;
         uid_locked_r <= 1'b0;
         eep_load_pending_r <= 1'b1;
      end else if (eep_load_pending_r && eep_sync_r[1] && eeprom_valid && !uid_locked_r) begin
         // lower quadlet loads together with the upper
         uid_upper_r <= eeprom_uid[63:32];
         uid_lower_r <= eeprom_uid[31:0];
         uid_locked_r <= 1'b1;
         eep_load_pending_r <= 1'b0;
      end
      // no host write path reaches the unique ID
   end

   // ROM map base; the low ten bits are not stored at all
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rom_base_r <= `ROM_BASE_RESET;
      end else if (wr_base) begin
         // Bits 9 to 0 of the write are dropped, so the read needs no mask
         rom_base_r <= reg_wdata[31:`ROM_BASE_LSB];
      end
   end

   // Read mux; unmapped offsets read zero
   always @* begin
      rd_nxt = 32'h00000000;
      case (reg_addr)
         `OFS_BUS_OPTIONS: begin
            // zero fields and speed code built in above
            rd_nxt = opt_word;
         end
         `OFS_UID_UPPER: rd_nxt = uid_upper_r;
         `OFS_UID_LOWER: rd_nxt = uid_lower_r;
         `OFS_ROM_MAP_BASE: rd_nxt = {rom_base_r, 10'h000};
         // Link-on reads back at bit 17 from either offset of the pair
         `OFS_HC_CONTROL_SET: rd_nxt = {14'h0000, link_on_r, 17'h00000};
         `OFS_HC_CONTROL_CLR: rd_nxt = {14'h0000, link_on_r, 17'h00000};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // Read data registered, answered one cycle after the strobe
   // Data holds between reads so that a slow host may pick it up late;
   // a read in the same cycle as a write to that offset returns the old value
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_r <= 32'h00000000;
         reg_rack_r <= 1'b0;
      end else begin
         reg_rack_r <= reg_rd;
         if (reg_rd) begin
            reg_rdata_r <= rd_nxt;
         end
      end
   end

   // oversized block writes flag a type error
   // Length is widened by one bit so the 64 KiB limit of code F compares cleanly
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_type_error_r <= 1'b0;
      end else begin
         wr_type_error_r <= wr_req_valid && ({1'b0, wr_req_len} > max_rec_bytes);
      end
   end

   // ROM read address translation
   // The translator answers from its own flops, so hit, miss and address stay registered
   rom_read_xlate u_xlate (
      .ref_clk(ref_clk),
      .rst(rst),
      .req_valid(rom_req_valid),
      .req_offset(rom_req_offset),
      .map_base(rom_base_r),
      .hit_r(rom_hit_r),
      .miss_r(rom_miss_r),
      .host_addr_r(rom_host_addr_r)
   );
endmodule

/* File: bus_info_checks_assertions.sv */
// Concurrent checks on the bus info and ROM map register ports
`timescale 1ns/1ps
module bus_info_checks (
   input wire ref_clk,
   input wire rst,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_rdata_r,
   input wire reg_rack_r,
   input wire uid_locked_r,
   input wire rom_req_valid,
   input wire [47:0] rom_req_offset,
   input wire rom_hit_r,
   input wire rom_miss_r,
   input wire [31:0] rom_host_addr_r
);
   reg rd_q;
   reg [7:0] rd_addr_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Offset falls in the 1 KiB configuration ROM window
   wire win = rom_req_offset[47:10] == 38'h3FFFFC0001;
   // Strobe and offset of the read that the current answer belongs to
   always @(posedge ref_clk) begin
      rd_q <= reg_rd;
      rd_addr_q <= reg_addr;
   end
   wire opt_rd = reg_rack_r && rd_q && (rd_addr_q == 8'h20);
   property p_hit; rom_req_valid && win |=> rom_hit_r && !rom_miss_r
      && rom_host_addr_r[9:0] == $past(rom_req_offset[9:0]); endproperty
   a_hit: assert property (p_hit) else $error("window read not translated");
   property p_miss; rom_req_valid && !win |=> rom_miss_r && !rom_hit_r; endproperty
   a_miss: assert property (p_miss) else $error("outside read not missed");
   property p_idle; !rom_req_valid |=> !rom_hit_r && !rom_miss_r; endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_opt; opt_rd |-> reg_rdata_r[11:8] == 4'h0 && reg_rdata_r[5:0] == 6'h02; endproperty
   a_opt: assert property (p_opt) else $error("reserved or speed bits wrong");
   property p_rec; opt_rd |-> reg_rdata_r[15:12] >= 4'h8; endproperty
   a_rec: assert property (p_rec) else $error("request size below 512");
   property p_base; reg_rack_r && $past(reg_addr) == 8'h34 |-> reg_rdata_r[9:0] == 10'h000;
   endproperty
   a_base: assert property (p_base) else $error("base low bits not zero");
   property p_uid0; reg_rack_r && !$past(uid_locked_r) && ($past(reg_addr) == 8'h24
      || $past(reg_addr) == 8'h28) |-> reg_rdata_r == 32'h00000000; endproperty
   a_uid0: assert property (p_uid0) else $error("unique ID not zero before load");
   property p_lock; uid_locked_r |=> uid_locked_r; endproperty
   a_lock: assert property (p_lock) else $error("unique ID lock dropped");
endmodule

/* File: uid_eeprom_model.sv */
// Serial EEPROM stand-in that offers the unique ID some cycles after reset
`timescale 1ns/1ps
module uid_eeprom_model #(
   parameter [63:0] UID = 64'h0123456789ABCDEF // Arbitrary ID value
) (
   input wire ref_clk,
   input wire rst,
   input wire fitted,
   output reg eeprom_present,
   output reg eeprom_valid,
   output reg [63:0] eeprom_uid
);
   reg [3:0] cnt_r;
   // Load delay after reset, only when fitted
   always @(posedge ref_clk or posedge rst) begin
      if (rst) cnt_r <= 4'h0;
      else if (fitted && cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
   end
   // Inverse pattern while not valid, so a stale value never looks right
   always @* begin
      eeprom_present = fitted;
      eeprom_valid = cnt_r == 4'hF;
      eeprom_uid = eeprom_valid ? UID : ~UID;
   end
endmodule

/* File: bus_info_and_rom_map_regs_bench.sv */
// Directed bench for the bus info and ROM map registers
`timescale 1ns/1ps
module bus_info_and_rom_map_regs_bench;
   reg ref_clk = 1'b0, rst = 1'b1, soft_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   reg rom_req_valid = 1'b0, wr_req_valid = 1'b0, fitted = 1'b0;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h00000000;
   reg [47:0] rom_req_offset = 48'h000000000000;
   reg [15:0] wr_req_len = 16'h0000;
   wire [31:0] reg_rdata_r, rom_host_addr_r;
   wire [63:0] eeprom_uid;
   wire reg_rack_r, eeprom_present, eeprom_valid, uid_locked_r, link_on_r;
   wire rom_hit_r, rom_miss_r, wr_type_error_r;
   integer n_mismatch = 0, n_tests = 0, i;
   // Free-running clock
   always #5 ref_clk = ~ref_clk;
   uid_eeprom_model eep (
      .ref_clk(ref_clk), .rst(rst), .fitted(fitted), .eeprom_present(eeprom_present),
      .eeprom_valid(eeprom_valid), .eeprom_uid(eeprom_uid));
   bus_info_and_rom_map_regs dut (
      .ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
      .reg_rack_r(reg_rack_r), .eeprom_present(eeprom_present), .eeprom_valid(eeprom_valid),
      .eeprom_uid(eeprom_uid), .uid_locked_r(uid_locked_r), .link_on_r(link_on_r),
      .rom_req_valid(rom_req_valid), .rom_req_offset(rom_req_offset), .rom_hit_r(rom_hit_r),
      .rom_miss_r(rom_miss_r), .rom_host_addr_r(rom_host_addr_r), .wr_req_valid(wr_req_valid),
      .wr_req_len(wr_req_len), .wr_type_error_r(wr_type_error_r));
   task chk(input [63:0] seen, input [63:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
         if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   // Strobes last one cycle; the answer is settled by the next falling edge
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(negedge ref_clk);
         reg_wr = 1'b1;
         reg_addr = a;
         reg_wdata = d;
         @(negedge ref_clk);
         reg_wr = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(negedge ref_clk);
         reg_rd = 1'b1;
         reg_addr = a;
         @(negedge ref_clk);
         reg_rd = 1'b0;
         chk(reg_rdata_r, e);
      end
   endtask
   task rq(input [47:0] o, input h, input [31:0] e);
      begin
         @(negedge ref_clk);
         rom_req_valid = 1'b1;
         rom_req_offset = o;
         @(negedge ref_clk);
         rom_req_valid = 1'b0;
         chk({rom_hit_r, rom_miss_r, rom_host_addr_r}, {h, ~h, e});
      end
   endtask
   task wl(input [15:0] n, input e);
      begin
         @(negedge ref_clk);
         wr_req_valid = 1'b1;
         wr_req_len = n;
         @(negedge ref_clk);
         wr_req_valid = 1'b0;
         chk(wr_type_error_r, e);
      end
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      rd(8'h20, 32'h0000A002);
      wl(16'd2049, 1'b1);
      wl(16'd2048, 1'b0);
      wr(8'h20, 32'hFFFF7FFF);
      rd(8'h20, 32'hF8FFA0C2);
      wr(8'h20, 32'h00008000);
      rd(8'h20, 32'h00008002);
      wl(16'd513, 1'b1);
      wl(16'd512, 1'b0);
      // Largest code: the 64 KiB limit must not wrap to a tiny one
      wr(8'h20, 32'h0000F000);
      wl(16'hFFFF, 1'b0);
      wr(8'h20, 32'hF8FF80C0);
      wr(8'h50, 32'h00020000);
      chk(link_on_r, 1'b1);
      @(negedge ref_clk);
      soft_rst = 1'b1;
      @(negedge ref_clk);
      soft_rst = 1'b0;
      chk(link_on_r, 1'b0);
      rd(8'h20, 32'h00008002);
      rd(8'h34, 32'h00000000);
      wr(8'h34, 32'hFFFFFFFF);
      rd(8'h34, 32'hFFFFFC00);
      rq(48'hFFFFF0000404, 1'b1, 32'hFFFFFC04);
      rq(48'hFFFFF00007FF, 1'b1, 32'hFFFFFFFF);
      rq(48'hFFFFF0000800, 1'b0, 32'hFFFFFFFF);
      rq(48'hFFFFF00003FC, 1'b0, 32'hFFFFFFFF);
      rd(8'h60, 32'h00000000);
      wr(8'h24, 32'hFFFFFFFF);
      rd(8'h24, 32'h00000000);
      rd(8'h28, 32'h00000000);
      fitted = 1'b1;
      // Bounded wait for the ID load; a timeout counts through the check below
      i = 0;
      while (uid_locked_r !== 1'b1 && i < 50) begin
         @(negedge ref_clk);
         i = i + 1;
      end
      chk(uid_locked_r, 1'b1);
      if (i < 50) begin
         rd(8'h24, 32'h01234567);
         wr(8'h28, 32'h00000000);
         rd(8'h28, 32'h89ABCDEF);
         // Second system reset in mid-run: code back to 2048 bytes, ID cleared
         @(negedge ref_clk);
         rst = 1'b1;
         repeat (2) @(negedge ref_clk);
         rst = 1'b0;
         rd(8'h20, 32'h0000A002);
         rd(8'h24, 32'h00000000);
         rd(8'h28, 32'h00000000);
         chk(uid_locked_r, 1'b0);
      end
      summarize;
   end
endmodule
bind bus_info_and_rom_map_regs bus_info_checks chk_i (
   .ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata_r(reg_rdata_r), .reg_rack_r(reg_rack_r), .uid_locked_r(uid_locked_r),
   .rom_req_valid(rom_req_valid), .rom_req_offset(rom_req_offset), .rom_hit_r(rom_hit_r),
   .rom_miss_r(rom_miss_r), .rom_host_addr_r(rom_host_addr_r));
